// ==== rts_pkg.sv ====
// Package for the reset and time-out sequencer: offsets, fields, timing, types.
package rts_pkg;

    // ==========================================================
    // Clock and timing
    localparam int MCLK_MHZ = 250;
    localparam int PWRUP_DELAY_MS = 72;
    localparam int BROWNOUT_MIN_US = 100;
    localparam int OSC_STARTUP_CYCLES = 1024;
    // Least time in clock cycles, exact product
    localparam int BROWNOUT_MIN_CYC = BROWNOUT_MIN_US * MCLK_MHZ;
    // RC tick divider of the power-up timer
    localparam int PWRUP_TICK_DIV = 250;
    localparam int PWRUP_TICKS = (PWRUP_DELAY_MS * 1000 * MCLK_MHZ) / PWRUP_TICK_DIV;
    localparam int CLKOUT_DIV = 4;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_POWER_STATUS = 12'h000;
    localparam logic [11:0] ADDR_CORE_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CONFIG = 12'h008;
    // Power status field positions
    localparam int BIT_BROWNOUT = 0;
    localparam int BIT_POWERON = 1;
    // Core status field positions
    localparam int BIT_PWRDN = 0;
    localparam int BIT_TO = 1;
    localparam int BIT_CAUSE = 4;
    // Config field positions
    localparam int BIT_OSC_LO = 0;
    localparam int BIT_OSC_HI = 1;
    localparam int BIT_TIMER_DIS = 3;
    localparam int BIT_DIP_EN = 6;
    localparam logic [7:0] POWER_STATUS_RST = 8'h00;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        OSC_LOW_POWER = 2'b00,
        OSC_CRYSTAL = 2'b01,
        OSC_HIGH_SPEED = 2'b10,
        OSC_RESISTOR_CAP = 2'b11
    } rts_osc_mode_t;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_POWER_ON = 3'h1,
        CAUSE_CLEAR_RUN = 3'h2,
        CAUSE_CLEAR_SLEEP = 3'h3,
        CAUSE_WATCHDOG = 3'h4,
        CAUSE_BROWNOUT = 3'h5
    } rts_cause_t;

    // Gray along HOLD -> TIMER -> SETTLE -> WAITPIN -> RUN
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_TIMER = 3'b001,
        ST_SETTLE = 3'b011,
        ST_WAITPIN = 3'b010,
        ST_RUN = 3'b110
    } rts_state_t;

    typedef struct packed {
        logic brownoutEnable;
        logic powerUpTimerDisable;
        rts_osc_mode_t oscMode;
    } rts_config_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } rts_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rts_apb_rsp_t;

endpackage : rts_pkg

// ==== rts_sequencer.sv ====
// Reset and start-up time-out sequencer with cause flags and APB registers.
`timescale 1ns/1ns
module rts_sequencer
    import rts_pkg::*;
#(
    parameter int PWRUP_TICKS_P = PWRUP_TICKS,
    parameter int BROWNOUT_CYC_P = BROWNOUT_MIN_CYC,
    parameter int CLEAR_FILTER_CYC = 8
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Reset sources
    input wire logic powerOnPulse,
    input wire logic masterClearN,
    input wire logic watchdogReset,
    input wire logic brownoutDetect,
    input wire logic sleepWake,
    input wire logic coreSleeping,
    // Oscillator
    input wire logic oscillatorInput,
    output logic oscillatorOutput,
    // Master-clear pin drive, never driven
    output logic masterClearOut,
    output logic masterClearOeN,
    // Core side
    output logic coreResetOut,
    output logic coreRetain,
    // APB slave
    input rts_pkg::rts_apb_req_t apbReq,
    output rts_pkg::rts_apb_rsp_t apbRsp
);
    import rts_pkg::*;

    // ==========================================================
    // Input synchronisers
    logic [2:0] clrSync_q;
    logic [2:0] oscSync_q;
    logic [2:0] dipSync_q;
    logic clrLevel_q;
    logic dipLevel_q;
    logic oscLevel_q;
    logic oscEdge;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            clrSync_q <= 3'h7;
            oscSync_q <= 3'h0;
            dipSync_q <= 3'h0;
            clrLevel_q <= 1'b1;
            dipLevel_q <= 1'b0;
            oscLevel_q <= 1'b0;
        end
        else
        begin
            clrSync_q <= {clrSync_q[1:0], masterClearN};
            oscSync_q <= {oscSync_q[1:0], oscillatorInput};
            dipSync_q <= {dipSync_q[1:0], brownoutDetect};
            if (clrSync_q[1] == clrSync_q[2])
                clrLevel_q <= clrSync_q[2];
            if (dipSync_q[1] == dipSync_q[2])
                dipLevel_q <= dipSync_q[2];
            if (oscSync_q[1] == oscSync_q[2])
                oscLevel_q <= oscSync_q[2];
        end
    end

    assign oscEdge = (oscSync_q[2] & oscSync_q[1]) & ~oscLevel_q;

    // ==========================================================
    // Configuration register
    rts_config_t cfg_q;
    logic apbWrite;
    logic apbRead;
    logic powerUpEnabled;
    logic crystalMode;

    assign apbWrite = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign apbRead = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
    assign powerUpEnabled = ~cfg_q.powerUpTimerDisable | cfg_q.brownoutEnable;
    assign crystalMode = (cfg_q.oscMode != OSC_RESISTOR_CAP);

    always_ff @(posedge mclk)
    begin
        if (srst)
            cfg_q <= '0;
        else if (apbWrite && apbReq.paddr == ADDR_CONFIG)
        begin
            cfg_q.oscMode <= rts_osc_mode_t'({apbReq.pwdata[BIT_OSC_HI], apbReq.pwdata[BIT_OSC_LO]});
            cfg_q.powerUpTimerDisable <= apbReq.pwdata[BIT_TIMER_DIS];
            cfg_q.brownoutEnable <= apbReq.pwdata[BIT_DIP_EN];
        end
    end

    // ==========================================================
    // Master-clear noise filter
    logic [15:0] clrCount_q;
    logic clrLow_q;
    logic clrLowPrev_q;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            clrCount_q <= '0;
            clrLow_q <= 1'b0;
            clrLowPrev_q <= 1'b0;
        end
        else
        begin
            clrLowPrev_q <= clrLow_q;
            if (clrLevel_q)
            begin
                clrCount_q <= '0;
                clrLow_q <= 1'b0;
            end
            else if (clrCount_q < 16'(CLEAR_FILTER_CYC))
                clrCount_q <= clrCount_q + 16'h0001;
            else
                clrLow_q <= 1'b1;
        end
    end

    // ==========================================================
    // Brown-out duration filter
    logic [31:0] dipCount_q;
    logic dipActive;

    always_ff @(posedge mclk)
    begin
        if (srst || !dipLevel_q || !cfg_q.brownoutEnable)
            dipCount_q <= '0;
        else if (dipCount_q < 32'(BROWNOUT_CYC_P))
            dipCount_q <= dipCount_q + 32'h1;
    end
    assign dipActive = cfg_q.brownoutEnable && dipCount_q >= 32'(BROWNOUT_CYC_P);

    // ==========================================================
    // Sequencer
    rts_state_t state_q;
    rts_cause_t cause_q;
    logic [31:0] tickDiv_q;
    logic [31:0] timerCount_q;
    logic [10:0] settleCnt_q;
    logic runSettle_q;
    logic rcTick;
    logic dipHeld_q;

    assign rcTick = (tickDiv_q == 32'(PWRUP_TICK_DIV - 1));

    always_ff @(posedge mclk)
    begin
        if (srst || state_q != ST_TIMER || rcTick)
            tickDiv_q <= '0;
        else
            tickDiv_q <= tickDiv_q + 32'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_q <= ST_HOLD;
            cause_q <= CAUSE_POWER_ON;
            timerCount_q <= '0;
            settleCnt_q <= '0;
            runSettle_q <= 1'b1;
            dipHeld_q <= 1'b0;
        end
        else if (powerOnPulse)
        begin
            state_q <= ST_HOLD;
            cause_q <= CAUSE_POWER_ON;
            runSettle_q <= 1'b1;
            dipHeld_q <= 1'b0;
        end
        else if (dipActive || (dipHeld_q && dipLevel_q))
        begin
            state_q <= ST_HOLD;
            cause_q <= CAUSE_BROWNOUT;
            runSettle_q <= 1'b1;
            dipHeld_q <= 1'b1;
        end
        else if (clrLow_q && !clrLowPrev_q && state_q == ST_RUN)
        begin
            state_q <= ST_WAITPIN;
            cause_q <= coreSleeping ? CAUSE_CLEAR_SLEEP : CAUSE_CLEAR_RUN;
        end
        else if (watchdogReset && state_q == ST_RUN)
        begin
            state_q <= ST_WAITPIN;
            cause_q <= CAUSE_WATCHDOG;
        end
        else if (sleepWake && state_q == ST_RUN && crystalMode)
        begin
            state_q <= ST_SETTLE;
            cause_q <= CAUSE_NONE;
            settleCnt_q <= '0;
            // Wake must count even after a plain reset
            runSettle_q <= 1'b1;
        end
        else
        begin
            unique case (state_q)
                ST_HOLD:
                begin
                    dipHeld_q <= 1'b0;
                    timerCount_q <= '0;
                    settleCnt_q <= '0;
                    state_q <= powerUpEnabled ? ST_TIMER : ST_SETTLE;
                end
                ST_TIMER:
                begin
                    if (rcTick)
                        timerCount_q <= timerCount_q + 32'h1;
                    if (timerCount_q >= 32'(PWRUP_TICKS_P))
                        state_q <= ST_SETTLE;
                end
                ST_SETTLE:
                begin
                    if (!crystalMode || !runSettle_q || settleCnt_q == 11'(OSC_STARTUP_CYCLES))
                        state_q <= ST_WAITPIN;
                    else if (oscEdge)
                        settleCnt_q <= settleCnt_q + 11'h001;
                end
                ST_WAITPIN:
                begin
                    runSettle_q <= 1'b0;
                    if (clrLevel_q)
                        state_q <= ST_RUN;
                end
                ST_RUN:
                    state_q <= ST_RUN;
                default:
                    state_q <= ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            coreResetOut <= 1'b1;
        else
            // Pin level gates release in WAITPIN; short pin glitches stay out
            coreResetOut <= (state_q != ST_RUN);
    end

    assign coreRetain = 1'b1;
    assign masterClearOut = 1'b0;
    assign masterClearOeN = 1'b1;

    // ==========================================================
    // Status flags
    logic timeoutN_q;
    logic powerdownN_q;
    logic brownoutFlag_q;
    logic powerOnFlag_q;
    logic causeEvent;

    assign causeEvent = (state_q == ST_HOLD) || (state_q == ST_WAITPIN && cause_q != CAUSE_NONE);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            timeoutN_q <= 1'b1;
            powerdownN_q <= 1'b1;
        end
        else if (causeEvent)
        begin
            unique case (cause_q)
                CAUSE_POWER_ON, CAUSE_BROWNOUT:
                begin
                    timeoutN_q <= 1'b1;
                    powerdownN_q <= 1'b1;
                end
                CAUSE_WATCHDOG:
                    timeoutN_q <= 1'b0;
                CAUSE_CLEAR_SLEEP:
                begin
                    timeoutN_q <= 1'b1;
                    powerdownN_q <= 1'b0;
                end
                CAUSE_CLEAR_RUN, CAUSE_NONE:
                    timeoutN_q <= timeoutN_q;
                default:
                    timeoutN_q <= timeoutN_q;
            endcase
        end
        else if (coreSleeping)
            powerdownN_q <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            brownoutFlag_q <= POWER_STATUS_RST[BIT_BROWNOUT];
            powerOnFlag_q <= POWER_STATUS_RST[BIT_POWERON];
        end
        else
        begin
            if (state_q == ST_HOLD && cause_q == CAUSE_BROWNOUT)
                brownoutFlag_q <= 1'b0;
            else if (apbWrite && apbReq.paddr == ADDR_POWER_STATUS)
                brownoutFlag_q <= apbReq.pwdata[BIT_BROWNOUT];
            if (state_q == ST_HOLD && cause_q == CAUSE_POWER_ON)
                powerOnFlag_q <= 1'b0;
            else if (apbWrite && apbReq.paddr == ADDR_POWER_STATUS)
                powerOnFlag_q <= apbReq.pwdata[BIT_POWERON];
        end
    end

    // ==========================================================
    // Clock output divider
    logic [1:0] clkDiv_q;

    // divide by four in RC mode
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            clkDiv_q <= 2'h0;
            oscillatorOutput <= 1'b0;
        end
        else if (cfg_q.oscMode == OSC_RESISTOR_CAP)
        begin
            if (oscEdge)
                clkDiv_q <= clkDiv_q + 2'h1;
            oscillatorOutput <= clkDiv_q[1];
        end
        else
            oscillatorOutput <= 1'b0;
    end

    // ==========================================================
    // APB read path
    logic [31:0] rdData;
    logic [31:0] prData_q;
    logic addrOk;

    always_comb
    begin
        rdData = 32'h0;
        addrOk = 1'b1;
        unique case (apbReq.paddr)
            ADDR_POWER_STATUS:
            begin
                rdData[BIT_POWERON] = powerOnFlag_q;
                rdData[BIT_BROWNOUT] = brownoutFlag_q;
            end
            ADDR_CORE_STATUS:
            begin
                rdData[BIT_PWRDN] = powerdownN_q;
                rdData[BIT_TO] = timeoutN_q;
                rdData[BIT_CAUSE +: 3] = cause_q;
            end
            ADDR_CONFIG:
            begin
                rdData[BIT_OSC_LO] = cfg_q.oscMode[0];
                rdData[BIT_OSC_HI] = cfg_q.oscMode[1];
                rdData[BIT_TIMER_DIS] = cfg_q.powerUpTimerDisable;
                rdData[BIT_DIP_EN] = cfg_q.brownoutEnable;
            end
            default:
                addrOk = 1'b0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            prData_q <= 32'h0;
        else if (apbReq.psel && !apbReq.penable)
            prData_q <= rdData;
    end

    // One driver for the whole response
    assign apbRsp = '{prdata: prData_q, pready: 1'b1, pslverr: apbReq.psel & apbReq.penable & ~addrOk};

    logic unusedRead;
    assign unusedRead = apbRead;

endmodule : rts_sequencer

// ==== rts_sequencer_sva.sv ====
// Port checker for the reset sequencer, bound to its top.
`timescale 1ns/1ns
module rts_sequencer_sva
    import rts_pkg::*;
#(
    parameter int CLEAR_FILTER_CYC = 8
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Sources
    input wire logic powerOnPulse,
    input wire logic masterClearN,
    input wire logic watchdogReset,
    input wire logic brownoutDetect,
    input wire logic sleepWake,
    // Outputs
    input wire logic oscillatorOutput,
    input wire logic masterClearOut,
    input wire logic masterClearOeN,
    input wire logic coreResetOut,
    input wire logic coreRetain,
    input wire rts_pkg::rts_apb_rsp_t apbRsp
);
    logic [7:0] lowCnt;
    logic [7:0] dipCnt;
    logic [4:0] sinceCause;
    logic cause;

    assign cause = srst | powerOnPulse | watchdogReset | sleepWake | (lowCnt > 8'h03) | (dipCnt > 8'h03);

    // ==========================================================
    // Helper counters
    always_ff @(posedge mclk)
    begin
        if (masterClearN)
            lowCnt <= 8'h00;
        else if (lowCnt != 8'hff)
            lowCnt <= lowCnt + 8'h01;
    end

    always_ff @(posedge mclk)
    begin
        if (!brownoutDetect)
            dipCnt <= 8'h00;
        else if (dipCnt != 8'hff)
            dipCnt <= dipCnt + 8'h01;
    end

    // Cycles since the last possible reset cause
    always_ff @(posedge mclk)
    begin
        if (cause)
            sinceCause <= 5'h00;
        else if (sinceCause != 5'h1f)
            sinceCause <= sinceCause + 5'h01;
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_pin_undriven;
        masterClearOeN && !masterClearOut;
    endproperty
    a_pin_undriven: assert property (p_pin_undriven)
        else $error("master-clear pin driven");

    property p_retain;
        coreRetain;
    endproperty
    a_retain: assert property (p_retain)
        else $error("retain mark dropped");

    property p_srst_hold;
        $fell(srst) |-> coreResetOut && !oscillatorOutput && apbRsp.prdata == 32'h0;
    endproperty
    a_srst_hold: assert property (p_srst_hold)
        else $error("outputs not in reset state");

    property p_clear_long;
        lowCnt == CLEAR_FILTER_CYC + 10 |-> coreResetOut;
    endproperty
    a_clear_long: assert property (p_clear_long)
        else $error("long clear pulse gave no reset");

    property p_release_pin;
        $fell(coreResetOut) |-> $past(masterClearN) && $past(masterClearN, 3);
    endproperty
    a_release_pin: assert property (p_release_pin)
        else $error("reset released with pin low");

    property p_watchdog;
        watchdogReset |-> ##[1:4] coreResetOut;
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog gave no reset");

    property p_poweron;
        powerOnPulse |-> ##[1:4] coreResetOut;
    endproperty
    a_poweron: assert property (p_poweron)
        else $error("power-on pulse gave no reset");

    property p_cause_only;
        $rose(coreResetOut) |-> sinceCause < 5'd24;
    endproperty
    a_cause_only: assert property (p_cause_only)
        else $error("reset without a lasting cause");
endmodule : rts_sequencer_sva

bind rts_sequencer rts_sequencer_sva #(.CLEAR_FILTER_CYC(CLEAR_FILTER_CYC)) rts_sequencer_sva_inst (
    .mclk(mclk), .srst(srst), .powerOnPulse(powerOnPulse), .masterClearN(masterClearN),
    .watchdogReset(watchdogReset), .brownoutDetect(brownoutDetect), .sleepWake(sleepWake),
    .oscillatorOutput(oscillatorOutput), .masterClearOut(masterClearOut),
    .masterClearOeN(masterClearOeN), .coreResetOut(coreResetOut), .coreRetain(coreRetain),
    .apbRsp(apbRsp)
);

// ==== rts_far_side.sv ====
// Far-side model: master-clear pin, supply monitor and crystal.
`timescale 1ns/1ns
module rts_far_side
    import rts_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Bench commands
    input wire logic holdClearLow,
    input wire logic supplyLow,
    // Pin drive from the device
    input wire logic masterClearOut,
    input wire logic masterClearOeN,
    // Lines to the device
    output logic masterClearN,
    output logic brownoutDetect,
    output logic oscillatorInput
);
    logic [1:0] oscCnt = 2'b00;

    // ==========================================================
    // Crystal, one period every four clocks
    always_ff @(posedge mclk)
    begin
        oscCnt <= oscCnt + 2'b01;
    end
    assign oscillatorInput = oscCnt[1];

    assign masterClearN = !masterClearOeN ? masterClearOut : !holdClearLow;
    assign brownoutDetect = supplyLow;
endmodule : rts_far_side

// ==== tb_rts_sequencer.sv ====
// Self-checking bench for the reset and time-out sequencer.
`timescale 1ns/1ns
module tb_rts_sequencer
    import rts_pkg::*;
;
    // ==========================================================
    // Settings and signals
    localparam int PT = 4;
    localparam int PLO = (PT - 1) * PWRUP_TICK_DIV;
    localparam int PHI = PT * PWRUP_TICK_DIV + 40;
    localparam int SETTLE = OSC_STARTUP_CYCLES * 4;
    localparam logic [11:0] ADDR_NONE = 12'h00c;
    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic [31:0] mask;
        logic err;
    } rts_row_t;
    localparam rts_row_t ROWS [13] = '{
        '{ADDR_CORE_STATUS, 1'b0, 32'h0, 32'h13, 32'h73, 1'b0},
        '{ADDR_POWER_STATUS, 1'b0, 32'h0, 32'h0, 32'h2, 1'b0},
        '{ADDR_CONFIG, 1'b0, 32'h0, 32'h0, 32'h4b, 1'b0},
        '{ADDR_CONFIG, 1'b1, 32'h1, 32'h0, 32'h0, 1'b0},
        '{ADDR_CONFIG, 1'b0, 32'h0, 32'h1, 32'h4b, 1'b0},
        '{ADDR_CONFIG, 1'b1, 32'h2, 32'h0, 32'h0, 1'b0},
        '{ADDR_CONFIG, 1'b0, 32'h0, 32'h2, 32'h4b, 1'b0},
        '{ADDR_CONFIG, 1'b1, 32'h3, 32'h0, 32'h0, 1'b0},
        '{ADDR_CONFIG, 1'b0, 32'h0, 32'h3, 32'h4b, 1'b0},
        '{ADDR_CONFIG, 1'b1, 32'h0, 32'h0, 32'h0, 1'b0},
        '{ADDR_CONFIG, 1'b0, 32'h0, 32'h0, 32'h4b, 1'b0},
        '{ADDR_NONE, 1'b1, 32'h3, 32'h0, 32'h0, 1'b1},
        '{ADDR_NONE, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b1}
    };
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic powerOnPulse = 1'b0;
    logic watchdogReset = 1'b0;
    logic coreSleeping = 1'b0;
    logic sleepWake = 1'b0;
    logic holdClearLow = 1'b0;
    logic supplyLow = 1'b0;
    logic masterClearN;
    logic brownoutDetect;
    logic oscillatorInput;
    logic oscillatorOutput;
    logic masterClearOut;
    logic masterClearOeN;
    logic coreResetOut;
    logic coreRetain;
    rts_apb_req_t apbReq = '0;
    rts_apb_rsp_t apbRsp;
    int failures = 0;
    int totalChecks = 0;

    rts_sequencer #(.PWRUP_TICKS_P(PT), .BROWNOUT_CYC_P(10), .CLEAR_FILTER_CYC(8)) rts_sequencer_inst (
        .mclk(mclk), .srst(srst), .powerOnPulse(powerOnPulse), .masterClearN(masterClearN),
        .watchdogReset(watchdogReset), .brownoutDetect(brownoutDetect), .sleepWake(sleepWake),
        .coreSleeping(coreSleeping), .oscillatorInput(oscillatorInput),
        .oscillatorOutput(oscillatorOutput), .masterClearOut(masterClearOut),
        .masterClearOeN(masterClearOeN), .coreResetOut(coreResetOut), .coreRetain(coreRetain),
        .apbReq(apbReq), .apbRsp(apbRsp)
    );
    rts_far_side rts_far_side_inst (
        .mclk(mclk), .holdClearLow(holdClearLow), .supplyLow(supplyLow),
        .masterClearOut(masterClearOut), .masterClearOeN(masterClearOeN),
        .masterClearN(masterClearN), .brownoutDetect(brownoutDetect), .oscillatorInput(oscillatorInput)
    );

    initial
    begin
        forever #2 mclk = ~mclk;
    end

    // ==========================================================
    // Tasks
    task automatic wrap_up();
        if (failures == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        totalChecks++;
        if (((got ^ exp) & mask) !== 32'h0)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_range(input int n, input int lo, input int hi);
        totalChecks++;
        if (n < lo || n > hi)
        begin
            failures++;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, n, lo, hi);
        end
    endtask : check_range

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        @(posedge mclk);
        apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (apbRsp.pready !== 1'b1 && n < 20);
        q = apbRsp.prdata;
        e = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (n >= 20)
        begin
            failures++;
            $display("[ERR] %0t bus timeout", $time);
            wrap_up();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(a, 1'b1, d, q, e);
    endtask : wr

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] q;
        logic e;
        apb(a, 1'b0, 32'h0, q, e);
        check_val(q, exp, mask);
    endtask : rd_check

    task automatic power_on();
        @(posedge mclk);
        powerOnPulse <= 1'b1;
        @(posedge mclk);
        powerOnPulse <= 1'b0;
    endtask : power_on

    // Waits for reset to show, then for its release
    task automatic wait_release(input int max, output int n);
        n = 0;
        while (coreResetOut !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        while (coreResetOut !== 1'b0 && n < max)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= max)
        begin
            failures++;
            $display("[ERR] %0t reset never released", $time);
            wrap_up();
        end
    endtask : wait_release

    // ==========================================================
    // Main sequence
    initial
    begin
        int n;
        int ri;
        int ro;
        logic pi;
        logic po;
        logic [31:0] q;
        logic e;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        wait_release(20000, n);
        check_range(n, PLO + SETTLE - 8, PHI + SETTLE);
        check_val({31'h0, oscillatorOutput}, 32'h0, 32'h1);
        foreach (ROWS[i])
        begin
            apb(ROWS[i].addr, ROWS[i].wr, ROWS[i].wdata, q, e);
            check_val(q, ROWS[i].exp, ROWS[i].mask);
            check_val({31'h0, e}, {31'h0, ROWS[i].err}, 32'h1);
        end
        wr(ADDR_POWER_STATUS, 32'h3);
        @(posedge mclk) watchdogReset <= 1'b1;
        @(posedge mclk) watchdogReset <= 1'b0;
        wait_release(PHI + 40, n);
        rd_check(ADDR_CORE_STATUS, 32'h41, 32'h73);
        rd_check(ADDR_POWER_STATUS, 32'h2, 32'h2);
        repeat (32) @(posedge mclk);
        holdClearLow <= 1'b1;
        repeat (2) @(posedge mclk);
        holdClearLow <= 1'b0;
        repeat (40) @(posedge mclk);
        check_val({31'h0, coreResetOut}, 32'h0, 32'h1);
        for (int s = 0; s < 2; s++)
        begin
            coreSleeping <= s[0];
            holdClearLow <= 1'b1;
            repeat (2000) @(posedge mclk);
            check_val({31'h0, coreResetOut}, 32'h1, 32'h1);
            holdClearLow <= 1'b0;
            coreSleeping <= 1'b0;
            wait_release(24, n);
            rd_check(ADDR_CORE_STATUS, s ? 32'h32 : 32'h20, s ? 32'h73 : 32'h70);
        end
        wr(ADDR_CONFIG, 32'h3);
        wr(ADDR_POWER_STATUS, 32'h3);
        power_on();
        wait_release(PHI + 40, n);
        check_range(n, PLO, PHI);
        rd_check(ADDR_POWER_STATUS, 32'h0, 32'h2);
        ri = 0;
        ro = 0;
        pi = oscillatorInput;
        po = oscillatorOutput;
        for (int k = 0; k < 160; k++)
        begin
            @(posedge mclk);
            ri += int'(oscillatorInput === 1'b1 && pi === 1'b0);
            ro += int'(oscillatorOutput === 1'b1 && po === 1'b0);
            pi = oscillatorInput;
            po = oscillatorOutput;
        end
        check_range(ro * 4, ri - 4, ri + 4);
        wr(ADDR_CONFIG, 32'h9);
        power_on();
        wait_release(PHI + SETTLE + 40, n);
        check_range(n, SETTLE - 8, SETTLE + 40);
        sleepWake <= 1'b1;
        @(posedge mclk) sleepWake <= 1'b0;
        wait_release(SETTLE + 40, n);
        check_range(n, SETTLE - 8, SETTLE + 40);
        wr(ADDR_CONFIG, 32'h49);
        power_on();
        wait_release(PHI + SETTLE + 40, n);
        check_range(n, PLO + SETTLE - 8, PHI + SETTLE);
        wr(ADDR_CONFIG, 32'h4b);
        wr(ADDR_POWER_STATUS, 32'h3);
        supplyLow <= 1'b1;
        repeat (3) @(posedge mclk);
        supplyLow <= 1'b0;
        repeat (40) @(posedge mclk);
        check_val({31'h0, coreResetOut}, 32'h0, 32'h1);
        supplyLow <= 1'b1;
        repeat (40) @(posedge mclk);
        check_val({31'h0, coreResetOut}, 32'h1, 32'h1);
        supplyLow <= 1'b0;
        repeat (300) @(posedge mclk);
        supplyLow <= 1'b1;
        repeat (40) @(posedge mclk);
        supplyLow <= 1'b0;
        wait_release(PHI + 40, n);
        check_range(n, PLO, PHI);
        rd_check(ADDR_POWER_STATUS, 32'h2, 32'h3);
        rd_check(ADDR_CORE_STATUS, 32'h53, 32'h73);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        wait_release(20000, n);
        rd_check(ADDR_CONFIG, 32'h0, 32'h4b);
        wrap_up();
    end
endmodule : tb_rts_sequencer
